// >>> core/nsov_core.sv
// definite-time negative-sequence overvoltage decision block with apb slave
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// How it works
// RULE1 - upstream supplies rms negative-sequence voltage in percent
// RULE2 - start while voltage exceeds level, 2..40 percent, default 30
// RULE3 - while above level, count delay 50..60000 ms, default 100, then trip
// RULE4 - start-only setting suppresses trip; start still follows comparison
// RULE5 - external block input holds start and trip inactive
// RULE6 - outputs combine internal statuses with setting and block input
// RULE7 - configuration enable bit switches whole function off
// RULE8 - dropping to or below level clears start and restarts timing
module nsov_core #(
  parameter int          TICK_CYC = nsov_pkg::TICK_CYCLES,
  parameter int          MEAS_W   = 8
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [MEAS_W-1:0]  neg_seq_voltage,
  input  wire logic               function_block_in,
  output logic                    general_start_out,
  output logic                    general_trip_out,
  output logic                    irq
);
  import nsov_pkg::*;

  localparam int TW = $clog2(TICK_CYC + 1);

  logic                enable_q;
  logic                start_only_q;
  logic [7:0]          level_q;
  logic [15:0]         delay_q;
  logic [IRQ_W-1:0]    irq_stat_q;
  logic [IRQ_W-1:0]    irq_en_q;
  logic [TW-1:0]       tick_cnt_q;
  logic [15:0]         ms_cnt_q;
  logic                start_q;
  logic                trip_q;
  logic [MEAS_W-1:0]   meas_q;
  nsov_state_t         state_q;
  logic                blk_s;
  logic                over;
  logic                tick;
  logic                wr;
  logic                rd;
  logic                active;
  logic                due;

  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v < lo) clamp16 = lo;
    else if (v > hi) clamp16 = hi;
    else clamp16 = v;
  endfunction

  nsov_sync u_blk_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (function_block_in),
    .dout  (blk_s)
  );

  // zero-wait slave: read data set up for the access cycle; a write
  // lands only at the access edge where pready is seen high
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr > ADDR_MEAS || paddr[1:0] != 2'b00);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q     <= ENABLE_RST;
      start_only_q <= START_ONLY_RST;
      level_q      <= LEVEL_RST;
      delay_q      <= DELAY_RST_MS;
    end else if (wr) begin
      case (paddr)
        ADDR_CTRL: begin
          enable_q     <= pwdata[CTRL_ENABLE_BIT];
          start_only_q <= pwdata[CTRL_START_ONLY_BIT];
        end
        ADDR_LEVEL: begin
          level_q <= 8'(clamp16({8'h00, pwdata[7:0]}, {8'h00, LEVEL_MIN},
                                {8'h00, LEVEL_MAX}));
        end
        ADDR_DELAY: begin
          delay_q <= clamp16(pwdata[15:0], DELAY_MIN_MS, DELAY_MAX_MS);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= '0;
    end else if (wr && paddr == ADDR_IRQ_EN) begin
      irq_en_q <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      case (paddr)
        ADDR_CTRL:     prdata <= {30'h0, start_only_q, enable_q};
        ADDR_LEVEL:    prdata <= {24'h0, level_q};
        ADDR_DELAY:    prdata <= {16'h0, delay_q};
        ADDR_STATUS:   prdata <= {29'h0, blk_s, trip_q, start_q};
        ADDR_IRQ_STAT: prdata <= {{(32-IRQ_W){1'b0}}, irq_stat_q};
        ADDR_IRQ_EN:   prdata <= {{(32-IRQ_W){1'b0}}, irq_en_q};
        ADDR_MEAS:     prdata <= {{(32-MEAS_W){1'b0}}, meas_q};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // measured value comes from logic on pclk, no synchroniser needed [RULE1]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_q <= '0;
    end else begin
      meas_q <= neg_seq_voltage;
    end
  end

  assign active = enable_q && !blk_s; // [RULE5] [RULE7]
  assign over   = active && (16'(meas_q) > {8'h00, level_q}); // [RULE2]
  assign tick   = (tick_cnt_q == TW'(TICK_CYC - 1));

  // millisecond prescaler restarts with each timing run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
    end else if (!over || tick) begin
      tick_cnt_q <= '0;                                         // [RULE8]
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= NSOV_IDLE;
      ms_cnt_q <= '0;
      start_q  <= 1'b0;
      trip_q   <= 1'b0;
    end else begin
      start_q <= over;                                          // [RULE2]
      case (state_q)
        NSOV_IDLE: begin
          ms_cnt_q <= '0;
          trip_q   <= 1'b0;
          if (over) state_q <= NSOV_TIME;
        end
        NSOV_TIME: begin
          if (!over) begin
            state_q  <= NSOV_IDLE;                              // [RULE8]
            ms_cnt_q <= '0;
          end else if (tick) begin
            if (due) begin
              state_q <= NSOV_TRIP;                             // [RULE3]
              trip_q  <= 1'b1;
            end
            ms_cnt_q <= ms_cnt_q + 16'h0001;
          end
        end
        NSOV_TRIP: begin
          if (!over) begin
            state_q <= NSOV_IDLE;                               // [RULE8]
            trip_q  <= 1'b0;
          end
        end
        default: state_q <= NSOV_IDLE;
      endcase
    end
  end

  // outputs combine statuses with start-only and disable terms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_start_out <= 1'b0;
      general_trip_out  <= 1'b0;
    end else begin
      general_start_out <= start_q && active;                   // [RULE6]
      general_trip_out  <= trip_q && active && !start_only_q;   // [RULE4]
    end
  end

  // set wins over a clear written in the same cycle
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  assign due = (ms_cnt_q + 16'h0001) >= delay_q;
  assign ev  = {start_q && !over,
                over && tick && due && state_q == NSOV_TIME,
                over && !start_q};
  assign clr = (wr && paddr == ADDR_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr) | ev;
      irq        <= |(((irq_stat_q & ~clr) | ev) & irq_en_q);
    end
  end
endmodule

// >>> core/nsov_pkg.sv
// package: register map, field positions, reset values, timing constants
package nsov_pkg;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_LEVEL     = 8'h04;
  localparam logic [7:0]  ADDR_DELAY     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS    = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_EN    = 8'h14;
  localparam logic [7:0]  ADDR_IRQ_CLR   = 8'h18;
  localparam logic [7:0]  ADDR_MEAS      = 8'h1C;

  localparam int CTRL_ENABLE_BIT     = 0;
  localparam int CTRL_START_ONLY_BIT = 1;
  localparam int ST_START_BIT        = 0;
  localparam int ST_TRIP_BIT         = 1;
  localparam int ST_BLOCK_BIT        = 2;
  localparam int IRQ_START_BIT       = 0;
  localparam int IRQ_TRIP_BIT        = 1;
  localparam int IRQ_DROP_BIT        = 2;
  localparam int IRQ_W               = 3;

  localparam logic [7:0]  LEVEL_MIN      = 8'h02;
  localparam logic [7:0]  LEVEL_MAX      = 8'h28;
  localparam logic [7:0]  LEVEL_RST      = 8'h1E;
  localparam logic [15:0] DELAY_MIN_MS   = 16'h0032;
  localparam logic [15:0] DELAY_MAX_MS   = 16'hEA60;
  localparam logic [15:0] DELAY_RST_MS   = 16'h0064;
  localparam logic        ENABLE_RST     = 1'b1;
  localparam logic        START_ONLY_RST = 1'b0;

  localparam int CLK_MHZ      = 250;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
  localparam int PIPE_STAGES  = 3;

  typedef enum logic [1:0] {
    NSOV_IDLE  = 2'b00,
    NSOV_TIME  = 2'b01,
    NSOV_TRIP  = 2'b11
  } nsov_state_t;
endpackage

// >>> core/nsov_sync.sv
// three-stage synchroniser with second/third agreement filter
`timescale 1ns/1ps
module nsov_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // change counts only once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= 1'b0;
    end else if (s2_q == s3_q) begin
      dout <= s3_q;
    end
  end
endmodule

// >>> tb/nsov_checker.sv
// checker: port-level timing relations of the overvoltage block
`timescale 1ns/1ps
module nsov_checker #(
  parameter int TICK_CYC = 4,
  parameter int MEAS_W   = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [MEAS_W-1:0] neg_seq_voltage,
  input wire logic              function_block_in,
  input wire logic              general_start_out,
  input wire logic              general_trip_out,
  input wire logic              irq
);
  import nsov_pkg::*;
  localparam int MINC = 50 * TICK_CYC - 3;
  logic [7:0]  lvl_q;
  logic        en_q, so_q;
  logic [15:0] st_cnt_q;
  logic [3:0]  ok_cnt_q;
  wire         wr = psel && penable && pready && pwrite;
  wire         ok = (neg_seq_voltage > lvl_q) && en_q && !function_block_in;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the settings, clamped like the block clamps them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= LEVEL_RST;
      en_q  <= ENABLE_RST;
      so_q  <= START_ONLY_RST;
    end else if (wr && paddr == ADDR_LEVEL) begin
      lvl_q <= (pwdata[7:0] < LEVEL_MIN) ? LEVEL_MIN :
               (pwdata[7:0] > LEVEL_MAX) ? LEVEL_MAX : pwdata[7:0];
    end else if (wr && paddr == ADDR_CTRL) begin
      en_q <= pwdata[CTRL_ENABLE_BIT];
      so_q <= pwdata[CTRL_START_ONLY_BIT];
    end
  end
  // saturating run lengths; long holds are not unrolled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_cnt_q <= 16'h0000;
      ok_cnt_q <= 4'h0;
    end else begin
      st_cnt_q <= !general_start_out ? 16'h0000 :
                  (&st_cnt_q) ? st_cnt_q : st_cnt_q + 16'h0001;
      ok_cnt_q <= !ok ? 4'h0 : (&ok_cnt_q) ? ok_cnt_q : ok_cnt_q + 4'h1;
    end
  end
  a_start_cause: assert property ($rose(general_start_out) |->
    $past(neg_seq_voltage, 3) > lvl_q) else $error("start without cause");
  a_start_follows: assert property (ok_cnt_q >= 4'hA |->
    general_start_out) else $error("start missing while over level");
  a_trip_delay: assert property ($rose(general_trip_out) |->
    st_cnt_q >= MINC) else $error("trip before delay elapsed");
  a_start_only: assert property (so_q [*4] |->
    !general_trip_out) else $error("trip in start-only mode");
  a_block_off: assert property (function_block_in [*8] |->
    !general_start_out && !general_trip_out) else $error("active in block");
  a_trip_start: assert property (general_trip_out |->
    general_start_out) else $error("trip without start");
  a_level_drop: assert property ((neg_seq_voltage <= lvl_q) [*4] |->
    !general_start_out) else $error("start held at or below level");
  a_disable_off: assert property (!en_q [*4] |->
    !general_start_out && !general_trip_out) else $error("active when off");
  c_start: cover property ($rose(general_start_out));
  c_trip: cover property ($rose(general_trip_out));
  c_block: cover property (function_block_in && general_trip_out);
endmodule
bind nsov_core nsov_checker #(.TICK_CYC(TICK_CYC), .MEAS_W(MEAS_W)) CHKR (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .neg_seq_voltage(neg_seq_voltage),
  .function_block_in(function_block_in), .irq(irq),
  .general_start_out(general_start_out), .general_trip_out(general_trip_out));

// >>> tb/nsov_upstream.sv
// upstream model: hands the commanded magnitude to the block
`timescale 1ns/1ps
module nsov_upstream #(
  parameter int MEAS_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [MEAS_W-1:0] cmd_value,
  output logic      [MEAS_W-1:0] neg_seq_voltage
);
  // one sample of latency, as a real sequence filter adds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      neg_seq_voltage <= '0;
    else
      neg_seq_voltage <= cmd_value;
  end
endmodule

// >>> tb/test_neg_seq_overvoltage_definite_time.sv
// bench: drives the overvoltage block over apb and the upstream model
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
  errors++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module test_neg_seq_overvoltage_definite_time;
  import nsov_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        blk, st, tr, irq;
  logic [7:0]  paddr, volt, vmeas;
  logic [31:0] pwdata, prdata, rd;
  int          errors, comparisons, k;
  nsov_core #(.TICK_CYC(4), .MEAS_W(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .neg_seq_voltage(vmeas),
    .function_block_in(blk), .general_start_out(st),
    .general_trip_out(tr), .irq(irq));
  nsov_upstream UP (.pclk(pclk), .presetn(presetn), .cmd_value(volt),
    .neg_seq_voltage(vmeas));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following setup never reassigns psel in this step
    @(posedge pclk);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // no fixed trip time is assumed; the bound only stops a hang
  task automatic wait_trip();
    k = 0;
    while (tr !== 1'b1 && k < 400) begin
      @(posedge pclk);
      k++;
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_regs();
    apb(1'b0, ADDR_LEVEL, 32'h0);
    `CHK("level reset", 32'h1E, rd)
    apb(1'b0, ADDR_DELAY, 32'h0);
    `CHK("delay reset", 32'h64, rd)
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h1, rd)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    $display("test regs done");
  endtask
  task automatic t_level();
    apb(1'b1, ADDR_LEVEL, 32'h14);
    volt <= 8'h14;
    cyc(8);
    `CHK("start at level", 1'b0, st)
    volt <= 8'h15;
    cyc(5);
    `CHK("start above level", 1'b1, st)
    volt <= 8'h00;
    cyc(5);
    `CHK("start after drop", 1'b0, st)
    $display("test level done");
  endtask
  task automatic t_trip();
    apb(1'b1, ADDR_DELAY, 32'h32);
    apb(1'b1, ADDR_IRQ_EN, 32'h2);
    volt <= 8'h28;
    wait_trip();
    `CHK("trip time", 1'b1, (k >= 200 && k <= 212))
    cyc(3);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    `CHK("irq status", 32'h7, rd)
    apb(1'b1, ADDR_IRQ_EN, 32'h0);
    cyc(2);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, ADDR_IRQ_EN, 32'h2);
    apb(1'b1, ADDR_IRQ_CLR, 32'h7);
    cyc(2);
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    `CHK("irq status cleared", 32'h0, rd)
    apb(1'b1, ADDR_CTRL, 32'h3);
    cyc(6);
    `CHK("start only trip", 1'b0, tr)
    `CHK("start only start", 1'b1, st)
    apb(1'b1, ADDR_CTRL, 32'h1);
    blk <= 1'b1;
    cyc(10);
    `CHK("blocked start", 1'b0, st)
    `CHK("blocked trip", 1'b0, tr)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("blocked status", 32'h4, rd)
    blk <= 1'b0;
    cyc(14);
    `CHK("released start", 1'b1, st)
    `CHK("released trip", 1'b0, tr)
    $display("test trip done");
  endtask
  task automatic t_drop();
    cyc(150);
    volt <= 8'h00;
    cyc(6);
    volt <= 8'h28;
    wait_trip();
    `CHK("retimed trip", 1'b1, (k >= 200 && k <= 212))
    apb(1'b0, ADDR_MEAS, 32'h0);
    `CHK("measured value", 32'h28, rd)
    apb(1'b1, ADDR_CTRL, 32'h0);
    cyc(6);
    `CHK("off start", 1'b0, st)
    `CHK("off trip", 1'b0, tr)
    volt <= 8'h00;
    apb(1'b1, ADDR_CTRL, 32'h1);
    $display("test drop done");
  endtask
  initial begin
    #120000;
    errors++;
    finish_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, blk} <= 5'h00;
    {paddr, volt, pwdata} <= '0;
    errors = 0;
    comparisons = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_level();
    t_trip();
    t_drop();
    finish_test();
  end
endmodule
